// ### hw/gp_port.sv
// general purpose pin port: registers on Avalon-MM, pin muxing, sticky events, blink
// assumes pins and native signals synchronous to mclk; rst synchronous active high
// Functional notes
// - registers decoded in 64-byte base-selected window
// - muxed pins start in native function
// - use bit 0: pin 0 or pair A
// - use 1 and control 25 give pair 5
// - use bits 3,4: pins or pci interrupt lines
// - use bit 11: pin or smbus alert
// - input pin activity lands in event status
// - invert bit picks active level per input
// - status sticky after two active samples
// - working states sample on pci clock, except s1 on mobile (rtc clock)
// - sleep states sample on rtc clock
// - output pins drive their level bit
// - pin 22 open drain, others driven
// - desktop pin 21 comes up high
// - bidir pins: read pin in, drive out
// - blink enable toggles pin 25 periodically
// - status routable to sci or smi
`timescale 1ns/1ns
module gp_port #(
	parameter bit MOBILE = 1'b0, // mobile variant: rtc sampling in s1, pin 21 not forced high
	parameter int BLINK_HALF = gp_pkg::BLINK_HALF_CYC // blink half period in mclk cycles
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:6] io_window_base,
	input wire logic [2:0] power_state,
	input wire logic pci_clk,
	input wire logic rtc_clk,
	input wire logic [31:0] gpio_in,
	output logic [31:0] gpio_out,
	output logic [31:0] gpio_oe_n,
	output logic pci_req_a_n,
	input wire logic pci_gnt_a_n,
	output logic pci_req_b_n,
	input wire logic pci_gnt_b_n,
	output logic pci_req_5_n,
	input wire logic pci_gnt_5_n,
	output logic [1:0] pci_interrupt_lines,
	output logic smb_alert_n,
	output logic system_control_interrupt,
	output logic system_management_interrupt,
	output logic irq
);
	// all register state of the port
	typedef struct packed {
		gp_pkg::gp_bus_t bus; // bus answer phase
		logic [31:0] rdata; // read data held for the answer cycle
		logic [31:0] use_sel; // 1 = pin in general purpose use
		logic [31:0] io_sel; // 1 = bidir pin is an input
		logic [31:0] level; // pin_level_register
		logic [31:0] blink; // output_blink_enable
		logic [31:0] invert; // input_polarity_invert
		logic [31:0] evt_sts; // general_event_status, write one to clear
		logic [31:0] route; // 1 = smi, 0 = sci
		logic [31:0] gen_ctl; // general_control_register
		logic [31:0] irq_mask; // 1 = status bit reaches irq
		logic [31:0] blink_cnt; // cycles left in this blink half
		logic blink_phase; // current blink level
	} gp_state_t;

	// level reset: desktop variant keeps pin 21 high, mobile drops it
	localparam logic [31:0] LVL_RST = MOBILE ?
		(gp_pkg::LVL_DEF & ~(32'h1 << gp_pkg::POS_HIGH_PIN)) :
		(gp_pkg::LVL_DEF | (32'h1 << gp_pkg::POS_HIGH_PIN));
	localparam logic [31:0] BLINK_RELOAD = 32'(BLINK_HALF - 1);

	localparam gp_state_t RST_VAL = '{
		bus: gp_pkg::BUS_IDLE,
		rdata: 32'h0,
		use_sel: 32'h0,
		io_sel: 32'h0,
		level: LVL_RST & (gp_pkg::OUT_MASK | gp_pkg::BIDIR_MASK),
		blink: 32'h0,
		invert: 32'h0,
		evt_sts: 32'h0,
		route: 32'h0,
		gen_ctl: 32'h0,
		irq_mask: 32'h0,
		blink_cnt: BLINK_RELOAD,
		blink_phase: 1'b0
	};

	// byte enables widened to a bit mask
	function automatic logic [31:0] be_bits(input logic [3:0] be);
		be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_bits

	// byte-lane write of the writable bits only
	function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = be_bits(be) & wmask;
		wr_merge = (old & ~m) | (wd & m);
	endfunction : wr_merge

	// address lies in the window chosen by the base register
	function automatic logic in_window(input logic [15:0] addr, input logic [15:6] base);
		in_window = (addr[15:gp_pkg::WIN_BITS] == base);
	endfunction : in_window

	gp_state_t st;
	gp_state_t next_st;
	gp_smp_if smp ();

	logic req; // read or write pending
	logic hit_win; // request decodes in the window
	logic [5:0] ofs; // offset inside the window
	logic pair5; // pins 1 and 17 carry pair 5
	logic [31:0] gpio_use; // inputs currently owned by general purpose use
	logic [31:0] lvl_read; // level readback
	logic [31:0] rd_value; // decoded read value
	logic [31:0] sts_clr; // status bits cleared by this write
	logic wr_now; // write takes effect this edge
	logic [31:0] pin_drive; // output values for output and bidir pins
	logic [31:0] pending; // unmasked status

	assign req = avs_read | avs_write;
	assign hit_win = in_window(avs_address, io_window_base);
	assign ofs = {avs_address[5:2], 2'b00};
	assign wr_now = avs_write & hit_win & (st.bus == gp_pkg::BUS_ANSWER);
	// one wait cycle, then the answer
	assign avs_waitrequest = req & (st.bus == gp_pkg::BUS_IDLE);
	assign avs_readdata = st.rdata;

	// pair 5 needs both the use bit and the control bit
	assign pair5 = st.use_sel[1] & st.gen_ctl[gp_pkg::POS_PAIR5];
	// pin 1 as plain input only while use 1 is set and pair 5 is off
	assign gpio_use = (gp_pkg::IN_MASK & ~gp_pkg::MUX_MASK) |
		(st.use_sel & gp_pkg::MUX_MASK & ~{30'h0, pair5, 1'b0});

	// sampler hookup: sleep states switch to rtc edges
	assign smp.pins = gpio_in;
	assign smp.invert = st.invert;
	assign smp.pci_clk = pci_clk;
	assign smp.rtc_clk = rtc_clk;
	assign smp.use_rtc = (power_state >= gp_pkg::PWR_S3) ||
		(MOBILE && power_state == gp_pkg::PWR_S1);

	gp_sampler u_sampler (
		.mclk(mclk),
		.rst(rst),
		.smp(smp)
	);

	// level readback: bidir inputs show the pin, everything else the register
	always_comb begin
		lvl_read = st.level & gp_pkg::OUT_MASK;
		lvl_read = lvl_read | (gp_pkg::BIDIR_MASK & st.io_sel & gpio_in);
		lvl_read = lvl_read | (gp_pkg::BIDIR_MASK & ~st.io_sel & st.level);
	end

	// read decode; holes and unimplemented bits give zero
	always_comb begin
		rd_value = 32'h0;
		if (hit_win) begin
			case (ofs)
				gp_pkg::OFS_USE_SEL: rd_value = (st.use_sel & gp_pkg::MUX_MASK) |
					(gp_pkg::USE_SEL_DEF & ~gp_pkg::MUX_MASK & gp_pkg::PIN_MASK);
				gp_pkg::OFS_IO_SEL: rd_value = (st.io_sel & gp_pkg::BIDIR_MASK) | gp_pkg::IN_MASK;
				gp_pkg::OFS_LEVEL: rd_value = lvl_read;
				gp_pkg::OFS_TTL: rd_value = gp_pkg::TTL_DEF & gp_pkg::PIN_MASK;
				gp_pkg::OFS_BLINK: rd_value = st.blink;
				gp_pkg::OFS_INVERT: rd_value = st.invert;
				gp_pkg::OFS_EVT_STS: rd_value = st.evt_sts;
				gp_pkg::OFS_ROUTE: rd_value = st.route;
				gp_pkg::OFS_GEN_CTL: rd_value = st.gen_ctl;
				gp_pkg::OFS_IRQ_MASK: rd_value = st.irq_mask;
				default: rd_value = 32'h0;
			endcase
		end
	end

	// write-one-to-clear of status, only on the answer edge
	assign sts_clr = (wr_now && ofs == gp_pkg::OFS_EVT_STS) ?
		(avs_writedata & be_bits(avs_byteenable) & gp_pkg::IN_MASK) : 32'h0;

	// next state: bus handshake, register writes, status, blink
	always_comb begin
		next_st = st;
		// bus phase: idle -> answer takes one wait cycle
		case (st.bus)
			gp_pkg::BUS_IDLE: begin
				if (req) begin
					next_st.bus = gp_pkg::BUS_ANSWER;
					next_st.rdata = avs_read ? rd_value : 32'h0;
				end
			end
			gp_pkg::BUS_ANSWER: begin
				next_st.bus = gp_pkg::BUS_IDLE;
			end
			default: begin
				next_st.bus = gp_pkg::BUS_IDLE;
			end
		endcase
		// writes touch only implemented bits of each register
		if (wr_now) begin
			case (ofs)
				gp_pkg::OFS_USE_SEL: next_st.use_sel = wr_merge(st.use_sel, avs_writedata,
					avs_byteenable, gp_pkg::MUX_MASK);
				gp_pkg::OFS_IO_SEL: next_st.io_sel = wr_merge(st.io_sel, avs_writedata,
					avs_byteenable, gp_pkg::BIDIR_MASK);
				gp_pkg::OFS_LEVEL: next_st.level = wr_merge(st.level, avs_writedata,
					avs_byteenable, gp_pkg::OUT_MASK | gp_pkg::BIDIR_MASK);
				gp_pkg::OFS_BLINK: next_st.blink = wr_merge(st.blink, avs_writedata,
					avs_byteenable, 32'h1 << gp_pkg::POS_BLINK_PIN);
				gp_pkg::OFS_INVERT: next_st.invert = wr_merge(st.invert, avs_writedata,
					avs_byteenable, gp_pkg::IN_MASK);
				gp_pkg::OFS_ROUTE: next_st.route = wr_merge(st.route, avs_writedata,
					avs_byteenable, gp_pkg::IN_MASK);
				gp_pkg::OFS_GEN_CTL: next_st.gen_ctl = wr_merge(st.gen_ctl, avs_writedata,
					avs_byteenable, 32'h1 << gp_pkg::POS_PAIR5);
				gp_pkg::OFS_IRQ_MASK: next_st.irq_mask = wr_merge(st.irq_mask, avs_writedata,
					avs_byteenable, gp_pkg::IN_MASK);
				default: begin
					next_st.use_sel = st.use_sel;
				end
			endcase
		end
		// sticky status: a new hit beats a clear in the same cycle
		next_st.evt_sts = (st.evt_sts & ~sts_clr) | (smp.hit & gpio_use);
		// blink timer runs only while enabled, so the phase restarts cleanly
		if (st.blink[gp_pkg::POS_BLINK_PIN]) begin
			if (st.blink_cnt == 32'h0) begin
				next_st.blink_cnt = BLINK_RELOAD;
				next_st.blink_phase = ~st.blink_phase;
			end else begin
				next_st.blink_cnt = st.blink_cnt - 32'h1;
			end
		end else begin
			next_st.blink_cnt = BLINK_RELOAD;
			next_st.blink_phase = st.level[gp_pkg::POS_BLINK_PIN];
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= RST_VAL;
		end else begin
			st <= next_st;
		end
	end

	// output pin values, with native grants muxed in
	always_comb begin
		pin_drive = st.level & (gp_pkg::OUT_MASK | gp_pkg::BIDIR_MASK);
		if (st.blink[gp_pkg::POS_BLINK_PIN]) begin
			pin_drive[gp_pkg::POS_BLINK_PIN] = st.blink_phase;
		end
		// native grants take pins 16 and 17 back from the level bits
		if (!st.use_sel[0]) begin
			pin_drive[16] = pci_gnt_a_n;
		end
		if (pair5) begin
			pin_drive[17] = pci_gnt_5_n;
		end else if (!st.use_sel[1]) begin
			pin_drive[17] = pci_gnt_b_n;
		end
		// open drain only ever pulls low
		pin_drive[gp_pkg::POS_OPEN_DRAIN] = 1'b0;
	end

	// pin enables: low while driving
	always_comb begin
		gpio_oe_n = ~(gp_pkg::OUT_MASK | (gp_pkg::BIDIR_MASK & ~st.io_sel));
		gpio_oe_n[gp_pkg::POS_OPEN_DRAIN] = st.level[gp_pkg::POS_OPEN_DRAIN];
	end
	assign gpio_out = pin_drive;

	// native inputs: idle high while the pin belongs to general purpose use
	assign pci_req_a_n = st.use_sel[0] ? 1'b1 : gpio_in[0];
	assign pci_req_b_n = (st.use_sel[1]) ? 1'b1 : gpio_in[1];
	assign pci_req_5_n = pair5 ? gpio_in[1] : 1'b1;
	assign pci_interrupt_lines[0] = st.use_sel[3] ? 1'b1 : gpio_in[3];
	assign pci_interrupt_lines[1] = st.use_sel[4] ? 1'b1 : gpio_in[4];
	assign smb_alert_n = st.use_sel[11] ? 1'b1 : gpio_in[11];

	// event routing: each unmasked status bit goes to sci or smi
	assign pending = st.evt_sts & st.irq_mask;
	assign system_control_interrupt = |(pending & ~st.route);
	assign system_management_interrupt = |(pending & st.route);
	assign irq = |pending;

	// checks sleep through reset; bus, muxing and pin rules side by side
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_window_miss: assert property ((avs_read && !avs_waitrequest && !hit_win) |->
		avs_readdata == 32'h0)
		else $error("read outside the window returned data");
	chk_reset_native: assert property ($past(rst) |-> st.use_sel == 32'h0 &&
		pci_req_a_n == gpio_in[0])
		else $error("muxed pins not native after reset");
	chk_pin21_reset: assert property ($past(rst) |->
		st.level[gp_pkg::POS_HIGH_PIN] == !MOBILE)
		else $error("pin 21 reset level wrong for the variant");
	chk_pair_a: assert property (!st.use_sel[0] |-> gpio_out[16] == pci_gnt_a_n)
		else $error("pair a not routed");
	chk_pair_five: assert property ((st.use_sel[1] && st.gen_ctl[25]) |->
		pci_req_5_n == gpio_in[1] && pci_req_b_n && gpio_out[17] == pci_gnt_5_n)
		else $error("pair 5 not routed");
	chk_status_set: assert property (|(smp.hit & gpio_use) |=>
		(st.evt_sts & $past(smp.hit & gpio_use)) == $past(smp.hit & gpio_use))
		else $error("active input did not set status");
	chk_status_sticky: assert property (1'b1 |=>
		(st.evt_sts & $past(st.evt_sts & ~sts_clr)) == $past(st.evt_sts & ~sts_clr))
		else $error("status dropped without a clear");
	// pin 17 carries the pair 5 grant while that pair is on, so leave it out then
	chk_output_level: assert property (st.use_sel[0] && st.use_sel[1] &&
		!st.gen_ctl[gp_pkg::POS_PAIR5] |->
		gpio_out[21:16] == st.level[21:16] && gpio_out[23] == st.level[23])
		else $error("output pin differs from level");
	chk_open_drain: assert property (gpio_out[22] == 1'b0 &&
		gpio_oe_n[22] == st.level[22])
		else $error("pin 22 not open drain");
	chk_bidir_dir: assert property (gpio_oe_n[28:27] == st.io_sel[28:27] &&
		(!st.io_sel[24] || lvl_read[24] == gpio_in[24]))
		else $error("bidir pin direction wrong");
	chk_blink_toggle: assert property ((st.blink[25] && st.blink_cnt == 32'h0) ##1
		st.blink[25] |-> gpio_out[25] != $past(gpio_out[25]))
		else $error("blink did not toggle");
	chk_irq_route: assert property (|(st.evt_sts & st.irq_mask & st.route) |->
		system_management_interrupt && irq)
		else $error("routed status missing on smi");
	chk_unimpl_zero: assert property (avs_read && !avs_waitrequest |->
		(avs_readdata & ~gp_pkg::PIN_MASK) == 32'h0)
		else $error("unimplemented bit read nonzero");

	// main scenarios worth seeing at least once
	cov_status_set: cover property (|smp.hit ##1 |st.evt_sts);
	cov_pair_five: cover property (pair5 && !pci_req_5_n);
	cov_blink_toggle: cover property (st.blink[25] ##1 $changed(st.blink_phase));
	cov_bus_write: cover property (avs_write && avs_waitrequest ##1 !avs_waitrequest);
	cov_smi: cover property ($rose(system_management_interrupt));
endmodule : gp_port

// ### common/gp_pkg.sv
// constants of the general purpose pin port: offsets, pin groups, reset values, timing
// assumes a 125 MHz mclk and a 64-byte register window on the bus
package gp_pkg;
	// register byte offsets inside the 64-byte window
	localparam logic [5:0] OFS_USE_SEL = 6'h00;
	localparam logic [5:0] OFS_IO_SEL = 6'h04;
	localparam logic [5:0] OFS_LEVEL = 6'h0c;
	localparam logic [5:0] OFS_TTL = 6'h14;
	localparam logic [5:0] OFS_BLINK = 6'h18;
	localparam logic [5:0] OFS_INVERT = 6'h2c;
	localparam logic [5:0] OFS_EVT_STS = 6'h30;
	localparam logic [5:0] OFS_ROUTE = 6'h34;
	localparam logic [5:0] OFS_GEN_CTL = 6'h38;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h3c;
	// window size in address bits (64 bytes)
	localparam int WIN_BITS = 6;
	// pin groups
	localparam logic [31:0] IN_MASK = 32'h000039db;
	localparam logic [31:0] OUT_MASK = 32'h00ff0000;
	localparam logic [31:0] BIDIR_MASK = 32'h1b000000;
	localparam logic [31:0] MUX_MASK = 32'h0000081b;
	localparam logic [31:0] PIN_MASK = IN_MASK | OUT_MASK | BIDIR_MASK;
	// reset values
	localparam logic [31:0] USE_SEL_DEF = 32'h1a003180;
	localparam logic [31:0] LVL_DEF = 32'h1b3f0000;
	localparam logic [31:0] TTL_DEF = 32'h06630000;
	// field positions
	localparam int POS_PAIR5 = 25;
	localparam int POS_BLINK_PIN = 25;
	localparam int POS_OPEN_DRAIN = 22;
	localparam int POS_HIGH_PIN = 21;
	// power state codes on the power_state input
	localparam logic [2:0] PWR_S0 = 3'h0;
	localparam logic [2:0] PWR_S1 = 3'h1;
	localparam logic [2:0] PWR_S3 = 3'h3;
	// blink half period
	localparam int MCLK_HZ = 125000000;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYC = MCLK_HZ / 1000 * BLINK_HALF_MS;
	// bus answer states
	typedef enum logic {BUS_IDLE, BUS_ANSWER} gp_bus_t;
endpackage : gp_pkg

// ### common/gp_smp_if.sv
// carrier between the port top and its input sampler
// assumes both ends run on the same mclk
`timescale 1ns/1ns
interface gp_smp_if;
	logic [31:0] pins; // raw pin levels
	logic [31:0] invert; // polarity per pin
	logic pci_clk; // working-state sample clock level
	logic rtc_clk; // sleep-state sample clock level
	logic use_rtc; // sample on rtc edges
	logic [31:0] hit; // one-cycle pulse: active on two samples
	modport sampler (input pins, input invert, input pci_clk, input rtc_clk, input use_rtc,
		output hit);
	modport owner (output pins, output invert, output pci_clk, output rtc_clk, output use_rtc,
		input hit);
endinterface : gp_smp_if

// ### hw/gp_sampler.sv
// input sampler: polarity, sample-clock choice, two-sample qualification
// assumes pci_clk and rtc_clk are slow levels synchronous to mclk
`timescale 1ns/1ns
module gp_sampler (
	input wire logic mclk,
	input wire logic rst,
	gp_smp_if.sampler smp
);
	// all sampler state
	typedef struct packed {
		logic pci_q; // last pci clock level
		logic rtc_q; // last rtc clock level
		logic [31:0] act_q; // activity at last sample
		logic [31:0] hit; // qualified activity pulse
	} gp_smp_state_t;

	gp_smp_state_t st;
	gp_smp_state_t next_st;
	logic tick;

	// sample edge of the chosen clock, then compare with the previous sample
	always_comb begin
		next_st = st;
		next_st.pci_q = smp.pci_clk;
		next_st.rtc_q = smp.rtc_clk;
		next_st.hit = '0;
		tick = smp.use_rtc ? (smp.rtc_clk & ~st.rtc_q) : (smp.pci_clk & ~st.pci_q);
		if (tick) begin
			// invert 1 makes a low level the active one
			next_st.act_q = (smp.pins ^ smp.invert) & gp_pkg::IN_MASK;
			next_st.hit = next_st.act_q & st.act_q;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign smp.hit = st.hit;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_hit_on_tick: assert property (|st.hit |-> $past(tick))
		else $error("hit without a sample edge");
	chk_hit_two_samples: assert property ((|st.hit) |-> (st.hit & ~st.act_q) == 32'h0)
		else $error("hit without activity on the latest sample");
endmodule : gp_sampler

// ### test/gp_board.sv
// board model: pin levels, pull-up on the open-drain pin, sample clock levels
// assumes design outputs settle within one mclk; ext is what the board drives
`timescale 1ns/1ns
module gp_board (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [31:0] ext,
	input wire logic [31:0] gpio_out,
	input wire logic [31:0] gpio_oe_n,
	output logic [31:0] gpio_in,
	output logic pci_clk,
	output logic rtc_clk
);
	logic [5:0] div; // shared divider for both sample clocks
	// pci level period 4 mclk, rtc period 64: rtc far slower, as on a board
	always_ff @(posedge mclk) begin
		if (rst) begin
			div <= 6'h00;
		end else begin
			div <= div + 6'h01;
		end
	end
	assign pci_clk = div[1];
	assign rtc_clk = div[5];
	// wire level from the design's enable; ext or the pull-up where it does not drive
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (gpio_oe_n[i] == 1'b0) begin
				gpio_in[i] = gpio_out[i];
			end else if (i == gp_pkg::POS_OPEN_DRAIN) begin
				gpio_in[i] = 1'b1;
			end else begin
				gpio_in[i] = ext[i];
			end
		end
	end
endmodule : gp_board

// ### test/gp_port_tb.sv
// self-checking bench of the pin port: bus, muxing, outputs, events, blink
// assumes gp_port, gp_sampler, gp_smp_if and gp_board are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module gp_port_tb;
	localparam logic [9:0] BASE = 10'h2a5; // window base, arbitrary
	logic mclk, rst, avs_read, avs_write, avs_waitrequest, pci_clk, rtc_clk;
	logic [15:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, ext, gpio_in, gpio_out, gpio_oe_n;
	logic [3:0] avs_byteenable;
	logic [2:0] power_state;
	logic pci_req_a_n, pci_gnt_a_n, pci_req_b_n, pci_gnt_b_n, pci_req_5_n, pci_gnt_5_n;
	logic [1:0] pci_interrupt_lines;
	logic smb_alert_n, system_control_interrupt, system_management_interrupt, irq, p, nat;
	int seed, errors, cmp_count, cyc, t;
	logic [31:0] d, w, inv, s, r;
	gp_port #(.MOBILE(1'b0), .BLINK_HALF(4)) DUT (.mclk(mclk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.io_window_base(BASE), .power_state(power_state), .pci_clk(pci_clk),
		.rtc_clk(rtc_clk), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.pci_req_a_n(pci_req_a_n), .pci_gnt_a_n(pci_gnt_a_n), .pci_req_b_n(pci_req_b_n),
		.pci_gnt_b_n(pci_gnt_b_n), .pci_req_5_n(pci_req_5_n), .pci_gnt_5_n(pci_gnt_5_n),
		.pci_interrupt_lines(pci_interrupt_lines), .smb_alert_n(smb_alert_n),
		.system_control_interrupt(system_control_interrupt),
		.system_management_interrupt(system_management_interrupt), .irq(irq));
	gp_board board (.mclk(mclk), .rst(rst), .ext(ext), .gpio_out(gpio_out),
		.gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .pci_clk(pci_clk), .rtc_clk(rtc_clk));
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// hang guard: whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// one bus access; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= wd;
		avs_byteenable <= be;
		// waitrequest and read data are taken at rising edges only
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50) begin
			errors++;
			end_of_test();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [5:0] o, input logic [31:0] v);
		logic [31:0] x;
		bus(1'b1, {BASE, o}, v, 4'hf, x);
	endtask : wr
	task automatic rd(input logic [5:0] o, output logic [31:0] v);
		bus(1'b0, {BASE, o}, 32'h0, 4'hf, v);
	endtask : rd
	// level read-back: implemented non-input pins only
	function automatic logic [31:0] lvl_exp(input logic [31:0] v);
		return v & gp_pkg::PIN_MASK & ~gp_pkg::IN_MASK;
	endfunction : lvl_exp
	// counts, verdict, end of run
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// pulse a pin pattern for n cycles, then read status
	task automatic pulse(input logic [31:0] v, input int n, output logic [31:0] st);
		wr(gp_pkg::OFS_EVT_STS, 32'hffffffff);
		ext <= v;
		repeat (n) @(posedge mclk);
		ext <= 32'h0;
		repeat (8) @(posedge mclk);
		rd(gp_pkg::OFS_EVT_STS, st);
	endtask : pulse
	// main sequence
	initial begin
		seed = 83;
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		{pci_gnt_a_n, pci_gnt_b_n, pci_gnt_5_n} = 3'h7;
		power_state = gp_pkg::PWR_S0;
		ext = 32'h0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		// reset state, window decode, holes
		rd(gp_pkg::OFS_USE_SEL, d); `CHK(d, gp_pkg::USE_SEL_DEF)
		bus(1'b1, {BASE + 10'h1, gp_pkg::OFS_LEVEL}, 32'h0, 4'hf, d);
		bus(1'b0, {BASE + 10'h1, gp_pkg::OFS_LEVEL}, 32'h0, 4'hf, d); `CHK(d, 32'h0)
		rd(gp_pkg::OFS_LEVEL, d); `CHK(d, lvl_exp(gp_pkg::LVL_DEF))
		rd(6'h08, d); `CHK(d, 32'h0)
		`CHK(gpio_out[21], 1'b1)
		// native routes, then general purpose use and pair 5
		for (int k = 0; k < 4; k++) begin
			if (k == 2) begin
				wr(gp_pkg::OFS_USE_SEL, 32'h0000081b);
				wr(gp_pkg::OFS_GEN_CTL, 32'h02000000);
			end
			nat = (k < 2);
			@(posedge mclk);
			ext <= $random(seed);
			{pci_gnt_a_n, pci_gnt_b_n, pci_gnt_5_n} <= 3'($random(seed));
			@(negedge mclk);
			`CHK(pci_req_a_n, nat ? ext[0] : 1'b1)
			`CHK(gpio_out[16], nat ? pci_gnt_a_n : 1'b1)
			`CHK(pci_req_b_n, nat ? ext[1] : 1'b1)
			`CHK(pci_req_5_n, nat ? 1'b1 : ext[1])
			`CHK(gpio_out[17], nat ? pci_gnt_b_n : pci_gnt_5_n)
			`CHK(pci_interrupt_lines, nat ? ext[4:3] : 2'h3)
			`CHK(smb_alert_n, nat ? ext[11] : 1'b1)
		end
		wr(gp_pkg::OFS_GEN_CTL, 32'h0);
		// random output levels, open drain on pin 22
		for (int k = 0; k < 3; k++) begin
			w = $random(seed);
			wr(gp_pkg::OFS_LEVEL, w);
			rd(gp_pkg::OFS_LEVEL, d); `CHK(d, lvl_exp(w))
			`CHK(gpio_out & 32'h1bbf0000, w & 32'h1bbf0000)
			`CHK(gpio_oe_n & 32'h1bbf0000, 32'h0)
			`CHK(gpio_oe_n[22], w[22])
		end
		// bidirectional pins turned to inputs read the wire
		wr(gp_pkg::OFS_IO_SEL, 32'hffffffff);
		ext <= $random(seed);
		rd(gp_pkg::OFS_IO_SEL, d); `CHK(d, gp_pkg::IN_MASK | gp_pkg::BIDIR_MASK)
		rd(gp_pkg::OFS_LEVEL, d); `CHK(d & gp_pkg::BIDIR_MASK, ext & gp_pkg::BIDIR_MASK)
		`CHK(gpio_oe_n & gp_pkg::BIDIR_MASK, gp_pkg::BIDIR_MASK)
		wr(gp_pkg::OFS_IO_SEL, 32'h0);
		// blink: half period 4 gives 4 toggles in 16 cycles
		wr(gp_pkg::OFS_BLINK, 32'hffffffff);
		rd(gp_pkg::OFS_BLINK, d); `CHK(d, 32'h02000000)
		p = gpio_out[25];
		t = 0;
		repeat (16) begin
			@(negedge mclk);
			if (gpio_out[25] !== p) t++;
			p = gpio_out[25];
		end
		`CHK(t, 4)
		wr(gp_pkg::OFS_BLINK, 32'h0);
		// random events with random polarity and routing, working states
		for (int k = 0; k < 6; k++) begin
			inv = $random(seed) & gp_pkg::IN_MASK;
			s = $random(seed) & gp_pkg::IN_MASK;
			r = $random(seed);
			@(posedge mclk);
			power_state <= k[0] ? gp_pkg::PWR_S1 : gp_pkg::PWR_S0;
			ext <= inv;
			wr(gp_pkg::OFS_INVERT, inv);
			wr(gp_pkg::OFS_ROUTE, r);
			wr(gp_pkg::OFS_IRQ_MASK, 32'hffffffff);
			wr(gp_pkg::OFS_EVT_STS, 32'hffffffff);
			ext <= inv ^ s;
			repeat (12) @(posedge mclk);
			ext <= inv;
			repeat (8) @(posedge mclk);
			rd(gp_pkg::OFS_EVT_STS, d); `CHK(d, s)
			@(negedge mclk);
			`CHK(system_control_interrupt, |(s & ~r))
			`CHK(system_management_interrupt, |(s & r))
			`CHK(irq, |s)
			bus(1'b1, {BASE, gp_pkg::OFS_EVT_STS}, 32'hffffffff, 4'h1, d);
			rd(gp_pkg::OFS_EVT_STS, d); `CHK(d, s & 32'hffffff00)
			wr(gp_pkg::OFS_IRQ_MASK, 32'h0);
			@(negedge mclk);
			`CHK(irq, 1'b0)
		end
		// sample clock choice: one-cycle, short and long pulses
		@(posedge mclk);
		ext <= 32'h0;
		wr(gp_pkg::OFS_INVERT, 32'h0);
		pulse(32'h80, 1, d); `CHK(d, 32'h0)
		pulse(32'h80, 10, d); `CHK(d, 32'h80)
		power_state <= gp_pkg::PWR_S3;
		pulse(32'h80, 10, d); `CHK(d, 32'h0)
		pulse(32'h80, 150, d); `CHK(d, 32'h80)
		end_of_test();
	end
endmodule : gp_port_tb
